// ---- bench/wdpr_core_model.sv ----
// Processor core and software model on the register bus.
`timescale 1ns/100ps
`default_nettype none
module wdpr_core_model (
    input wire logic mclk_in,
    input wire logic [7:0] sfr_rdata_in,
    output var logic [7:0] sfr_addr_out,
    output var logic [7:0] sfr_wdata_out,
    output var logic sfr_wr_out,
    output var logic irq_out
);
    initial begin
        sfr_addr_out = 8'h00;
        sfr_wdata_out = 8'h00;
        sfr_wr_out = 1'b0;
        irq_out = 1'b0;
    end
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1;
        sfr_addr_out = a;
        sfr_wdata_out = d;
        sfr_wr_out = 1'b1;
        @(posedge mclk_in);
        #1;
        sfr_wr_out = 1'b0;
        sfr_wdata_out = ~d;
    endtask
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        #1;
        sfr_addr_out = a;
        @(posedge mclk_in);
        #2;
        d = sfr_rdata_in;
    endtask
    // Software restart keeps the watchdog from firing.
    task automatic kick(input logic [7:0] ctrl);
        sfr_write(8'h8F, ctrl | 8'h40);
    endtask
endmodule // wdpr_core_model
`default_nettype wire

// ---- bench/wdpr_top_assertions.sv ----
// Port checker of the watchdog and power block.
`timescale 1ns/100ps
`default_nettype none
module wdpr_top_assertions (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic reset_pin_in,
    input wire logic irq_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic sys_reset_out,
    input wire logic cpu_clk_en_out,
    input wire logic periph_clk_en_out,
    input wire logic osc_run_out,
    input wire logic idle_out,
    input wire logic powerdown_out,
    input wire logic wdt_timeout_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence idle_write_s;
        sfr_wr_in && sfr_addr_in == 8'h87 && sfr_wdata_in[0] && !irq_in && !sys_reset_out;
    endsequence
    sequence pd_write_s;
        sfr_wr_in && sfr_addr_in == 8'h87 && sfr_wdata_in[1] && !sys_reset_out;
    endsequence
    timeout_reset_a: assert property (wdt_timeout_out |=> sys_reset_out[*8])
        else $error("time-out gave no system reset");
    timeout_pulse_a: assert property (wdt_timeout_out |=> !wdt_timeout_out)
        else $error("time-out pulse too long");
    release_state_a: assert property ($fell(rst_in) |-> sys_reset_out && sfr_rdata_out == 8'h00 && !idle_out && !powerdown_out)
        else $error("state after reset wrong");
    cpu_half_rate_a: assert property (cpu_clk_en_out |=> !cpu_clk_en_out)
        else $error("processor enable faster than half rate");
    periph_half_a: assert property (periph_clk_en_out |=> !periph_clk_en_out)
        else $error("peripheral enable faster than half rate");
    idle_entry_a: assert property (idle_write_s |-> ##2 idle_out)
        else $error("idle not entered");
    idle_stop_a: assert property (idle_out |-> !cpu_clk_en_out)
        else $error("processor clocked in idle");
    idle_exit_a: assert property (idle_out && irq_in |-> ##2 !idle_out)
        else $error("interrupt did not end idle");
    pd_entry_a: assert property (pd_write_s |-> ##2 (powerdown_out && !osc_run_out))
        else $error("power-down not entered");
    pd_stop_a: assert property (powerdown_out |-> !osc_run_out && !periph_clk_en_out && !cpu_clk_en_out)
        else $error("clock running in power-down");
endmodule // wdpr_top_assertions
`default_nettype wire

// ---- bench/wdpr_top_tb.sv ----
// Self-checking testbench of the watchdog and power block.
`timescale 1ns/100ps
`default_nettype none
module wdpr_top_tb;
    logic mclk_in, rst_in, reset_pin_in, irq_in, sfr_wr_in;
    logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, rd;
    logic sys_reset_out, cpu_clk_en_out, periph_clk_en_out, osc_run_out;
    logic idle_out, powerdown_out, wdt_timeout_out, rst_seen, cpu_seen, per_seen, to_seen;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rows [5] = '{32'h0087_0010, 32'h018F_3F27, 32'h018F_A5A5,
        32'h0187_0C0C, 32'h0155_FF00};
    wdpr_top i_wdpr_top (.mclk_in(mclk_in), .rst_in(rst_in), .reset_pin_in(reset_pin_in),
        .irq_in(irq_in), .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rdata_out(sfr_rdata_out), .sys_reset_out(sys_reset_out),
        .cpu_clk_en_out(cpu_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
        .osc_run_out(osc_run_out), .idle_out(idle_out), .powerdown_out(powerdown_out),
        .wdt_timeout_out(wdt_timeout_out));
    wdpr_core_model i_wdpr_core_model (.mclk_in(mclk_in), .sfr_rdata_in(sfr_rdata_out),
        .sfr_addr_out(sfr_addr_in), .sfr_wdata_out(sfr_wdata_in), .sfr_wr_out(sfr_wr_in),
        .irq_out(irq_in));
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles++;
        rst_seen |= sys_reset_out;
        cpu_seen |= cpu_clk_en_out;
        per_seen |= periph_clk_en_out;
        to_seen |= wdt_timeout_out;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        i_wdpr_core_model.sfr_read(a, rd);
        check(rd, exp);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        rst_in = 1'b1;
        reset_pin_in = 1'b0;
        repeat (8) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        foreach (rows[i]) begin
            if (rows[i][24])
                i_wdpr_core_model.sfr_write(rows[i][23:16], rows[i][15:8]);
            rd_check(rows[i][23:16], rows[i][7:0]);
        end
        $display("register table done");
        i_wdpr_core_model.kick(8'h80);
        repeat (14) @(posedge mclk_in);
        rd_check(8'h8F, 8'h80);
        $display("clear bit done");
        i_wdpr_core_model.sfr_write(8'h8F, 8'hA5);
        i_wdpr_core_model.sfr_write(8'h87, 8'h0D);
        @(posedge mclk_in);
        #1 {cpu_seen, per_seen} = 2'b00;
        repeat (6) @(posedge mclk_in);
        check({idle_out, cpu_seen, per_seen}, 8'h05);
        #1 i_wdpr_core_model.irq_out = 1'b1;
        @(posedge mclk_in);
        #1 i_wdpr_core_model.irq_out = 1'b0;
        @(posedge mclk_in);
        #1 check({7'h00, idle_out}, 8'h00);
        $display("idle done");
        rst_seen = 1'b0;
        reset_pin_in = 1'b1;
        repeat (11) @(posedge mclk_in);
        #1 reset_pin_in = 1'b0;
        repeat (40) @(posedge mclk_in);
        check({7'h00, rst_seen}, 8'h00);
        #1 reset_pin_in = 1'b1;
        repeat (40) @(posedge mclk_in);
        #1 reset_pin_in = 1'b0;
        repeat (40) @(posedge mclk_in);
        check({7'h00, rst_seen}, 8'h01);
        rd_check(8'h8F, 8'h00);
        rd_check(8'h87, 8'h00);
        $display("pin reset done");
        i_wdpr_core_model.sfr_write(8'h87, 8'h02);
        #1 i_wdpr_core_model.irq_out = 1'b1;
        repeat (4) @(posedge mclk_in);
        #1 i_wdpr_core_model.irq_out = 1'b0;
        check({powerdown_out, osc_run_out}, 8'h02);
        rst_in = 1'b1;
        repeat (2) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        rd_check(8'h87, 8'h10);
        $display("power-down done");
        i_wdpr_core_model.kick(8'h80);
        repeat (14) @(posedge mclk_in);
        #1 i_wdpr_top.cnt_q = 14'h3FFF;
        {to_seen, rst_seen} = 2'b00;
        repeat (30) @(posedge mclk_in);
        check({6'h00, to_seen, rst_seen}, 8'h03);
        repeat (30) @(posedge mclk_in);
        rd_check(8'h8F, 8'h00);
        rd_check(8'h87, 8'h10);
        $display("time-out done");
        print_verdict();
    end
endmodule // wdpr_top_tb
bind wdpr_top wdpr_top_assertions i_wdpr_top_assertions (.mclk_in(mclk_in), .rst_in(rst_in),
    .reset_pin_in(reset_pin_in), .irq_in(irq_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rdata_out(sfr_rdata_out),
    .sys_reset_out(sys_reset_out), .cpu_clk_en_out(cpu_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out), .osc_run_out(osc_run_out), .idle_out(idle_out),
    .powerdown_out(powerdown_out), .wdt_timeout_out(wdt_timeout_out));
`default_nettype wire

// ---- common/wdpr_regs.vh ----
// Register map, field positions, reset values and timing counts of the watchdog block.
`ifndef WDPR_REGS_VH
`define WDPR_REGS_VH

// Special function register addresses.
`define WDPR_ADDR_WDOG_CTRL 8'h8F
`define WDPR_ADDR_POWER_CTRL 8'h87

// Watchdog control fields.
`define WDPR_WC_RUN_ENABLE 7
`define WDPR_WC_CLEAR_BIT 6
`define WDPR_WC_IDLE_RUN 5
`define WDPR_WC_SEL_HI 2
`define WDPR_WC_SEL_LO 0
`define WDPR_WC_RESET 8'h00

// Power control fields.
`define WDPR_PC_POWER_OFF 4
`define WDPR_PC_GEN_FLAG1 3
`define WDPR_PC_GEN_FLAG0 2
`define WDPR_PC_POWERDOWN 1
`define WDPR_PC_IDLE 0
`define WDPR_PC_RESET 8'h00

// Prescaler select codes, named by the division ratio.
`define WDPR_PS_DIV2 3'h0
`define WDPR_PS_DIV4 3'h2
`define WDPR_PS_DIV8 3'h1
`define WDPR_PS_DIV16 3'h3
`define WDPR_PS_DIV32 3'h4
`define WDPR_PS_DIV64 3'h5
`define WDPR_PS_DIV128 3'h6
`define WDPR_PS_DIV256 3'h7

// Clock and machine cycle timing.
`define WDPR_CLK_NS 100
`define WDPR_MC_NS 1200
`define WDPR_OSC_PER_MC (`WDPR_MC_NS / `WDPR_CLK_NS)
`define WDPR_STATES_PER_MC 3'h6
`define WDPR_LAST_STATE 3'h5

// Reset pin is sampled in state five, second phase.
`define WDPR_SAMPLE_STATE 3'h4
`define WDPR_SAMPLE_PHASE 1'h1

// Machine cycles of internal reset after a watchdog time-out.
`define WDPR_WDT_RST_MC 2'h2

// Watchdog counter width and terminal value.
`define WDPR_CNT_W 14
`define WDPR_CNT_LAST 14'h3FFF

`endif

// ---- src/wdpr_reset_filter.v ----
// Reset pin sampler and glitch filter.
`timescale 1ns/100ps
`default_nettype none

module wdpr_reset_filter (
    input wire mclk_in,
    input wire rst_in,
    input wire sample_en_in,
    input wire pin_in,
    output reg reset_out
);

    reg s1_q;

    // A reset is taken only after two successive high samples, one per
    // machine cycle, so a glitch caught by a single sample is ignored.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            s1_q <= 1'b0;
            reset_out <= 1'b0;
        end else if (sample_en_in) begin
            s1_q <= pin_in;
            reset_out <= pin_in & s1_q;
        end
    end

endmodule // wdpr_reset_filter

`default_nettype wire

// ---- src/wdpr_top.v ----
// Watchdog timer with power management and reset control.
`timescale 1ns/100ps
`default_nettype none
`include "wdpr_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Divider chain with selectable output, stepping only while counting is allowed.
// - Enabled time-out forces a system reset.
// - Any reset leaves the watchdog disabled.
// - Control register at 8FH, bit 7 enables.
// - Bit 6 clears counter and prescaler, self-clears.
// - Clear takes effect on next instruction cycle.
// - Bit 5 keeps watchdog running in idle.
// - Three select bits choose ratio 2 to 256.
// - Time-out is osc period times 2^14, ratio, 12.
// - Every reset clears the watchdog counter.
// - Input clock is divided by two internally.
// - Idle stops processor clock; interrupt or reset exits.
// - Power-down stops all clocks; only reset exits.
// - Reset pin high two machine cycles, sampled once.
// - Reset clears power control except power-off flag.
// - Short glitches on reset pin are ignored.
// - Power-off flag in bit 4, set at power-on.
module wdpr_top (
    input wire mclk_in,
    input wire rst_in,
    input wire reset_pin_in,
    input wire irq_in,
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_wdata_in,
    input wire sfr_wr_in,
    output reg [7:0] sfr_rdata_out,
    output reg sys_reset_out,
    output reg cpu_clk_en_out,
    output reg periph_clk_en_out,
    output reg osc_run_out,
    output reg idle_out,
    output reg powerdown_out,
    output reg wdt_timeout_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Clock division and machine cycle timing.

    reg phase_q;
    reg [2:0] state_q;
    wire mc_tick;
    wire sample_en;

    // The oscillator is halved first so that its duty cycle is irrelevant.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    // Six states make one machine cycle; each state lasts two phases.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            state_q <= 3'h0;
        end else if (phase_q) begin
            if (state_q == `WDPR_LAST_STATE) begin
                state_q <= 3'h0;
            end else begin
                state_q <= state_q + 3'h1;
            end
        end
    end

    // One machine cycle is six states of two phases, twelve oscillator periods;
    // mc_tick marks its last phase, where counts and the clear bit move.
    assign mc_tick = phase_q & (state_q == `WDPR_LAST_STATE);
    assign sample_en = (phase_q == `WDPR_SAMPLE_PHASE) &
        (state_q == `WDPR_SAMPLE_STATE);

    ////////////////////////////////////////////////////////////////////////////
    // Reset sources.

    wire pin_reset;
    reg [1:0] wdt_hold_q;
    reg wdt_fire_q;
    wire wdt_reset;
    wire any_reset;

    // The pin is looked at only once per machine cycle, in the fifth state.
    wdpr_reset_filter u_reset_filter (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .sample_en_in(sample_en),
        .pin_in(reset_pin_in),
        .reset_out(pin_reset)
    );

    // The watchdog reset covers the fire pulse and the hold that follows it;
    // with the pin reset it clears both control registers but the power-off flag.
    assign wdt_reset = wdt_fire_q | (wdt_hold_q != 2'h0);
    assign any_reset = rst_in | pin_reset | wdt_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes.

    reg wc_run_en_q;
    reg wc_clear_q;
    reg wc_idle_run_q;
    reg [2:0] wc_sel_q;
    reg pc_pof_q;
    reg pc_gf1_q;
    reg pc_gf0_q;
    reg pc_pd_q;
    reg pc_idle_q;
    wire wr_wc;
    wire wr_pc;

    // Writes are decoded on the full address; other addresses are ignored.
    assign wr_wc = sfr_wr_in & (sfr_addr_in == `WDPR_ADDR_WDOG_CTRL);
    assign wr_pc = sfr_wr_in & (sfr_addr_in == `WDPR_ADDR_POWER_CTRL);

    // Every reset source returns the watchdog control to all zero.
    always @(posedge mclk_in) begin
        if (any_reset) begin
            wc_run_en_q <= 1'b0;
            wc_idle_run_q <= 1'b0;
            wc_sel_q <= 3'h0;
        end else if (wr_wc) begin
            wc_run_en_q <= sfr_wdata_in[`WDPR_WC_RUN_ENABLE];
            wc_idle_run_q <= sfr_wdata_in[`WDPR_WC_IDLE_RUN];
            wc_sel_q <= sfr_wdata_in[`WDPR_WC_SEL_HI:`WDPR_WC_SEL_LO];
        end
    end

    // The clear bit stays up until the end of the current machine cycle, so
    // the prescaler and counter are zeroed on the same edge that drops it.
    // A fresh write of one wins over the self-clear in the same cycle.
    always @(posedge mclk_in) begin
        if (any_reset) begin
            wc_clear_q <= 1'b0;
        end else if (wr_wc & sfr_wdata_in[`WDPR_WC_CLEAR_BIT]) begin
            wc_clear_q <= 1'b1;
        end else if (mc_tick) begin
            wc_clear_q <= 1'b0;
        end
    end

    // Power control: only the power-on reset sets the power-off flag; the
    // pin and watchdog resets clear the rest of the register.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            pc_pof_q <= 1'b1;
        end else if (wr_pc & ~sfr_wdata_in[`WDPR_PC_POWER_OFF]) begin
            pc_pof_q <= 1'b0;
        end
    end

    // General flags and power-down follow software writes.
    always @(posedge mclk_in) begin
        if (any_reset) begin
            pc_gf1_q <= 1'b0;
            pc_gf0_q <= 1'b0;
            pc_pd_q <= 1'b0;
        end else if (wr_pc) begin
            pc_gf1_q <= sfr_wdata_in[`WDPR_PC_GEN_FLAG1];
            pc_gf0_q <= sfr_wdata_in[`WDPR_PC_GEN_FLAG0];
            pc_pd_q <= sfr_wdata_in[`WDPR_PC_POWERDOWN];
        end
    end

    // An interrupt ends idle, even against a write in the same cycle.
    always @(posedge mclk_in) begin
        if (any_reset) begin
            pc_idle_q <= 1'b0;
        end else if (irq_in) begin
            pc_idle_q <= 1'b0;
        end else if (wr_pc) begin
            pc_idle_q <= sfr_wdata_in[`WDPR_PC_IDLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads.

    wire [7:0] wc_read;
    wire [7:0] pc_read;

    assign wc_read = {wc_run_en_q, wc_clear_q, wc_idle_run_q, 2'b00, wc_sel_q};
    assign pc_read = {3'b000, pc_pof_q, pc_gf1_q, pc_gf0_q, pc_pd_q, pc_idle_q};

    // Read data follows the address one clock later; unmapped reads give zero.
    // Unused bits of both registers read as zero.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            sfr_rdata_out <= 8'h00;
        end else begin
            case (sfr_addr_in)
                `WDPR_ADDR_WDOG_CTRL: begin
                    sfr_rdata_out <= wc_read;
                end
                `WDPR_ADDR_POWER_CTRL: begin
                    sfr_rdata_out <= pc_read;
                end
                default: begin
                    sfr_rdata_out <= 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog prescaler and counter.

    reg [7:0] pre_q;
    reg [7:0] pre_last;
    reg [`WDPR_CNT_W-1:0] cnt_q;
    wire wdt_run;
    wire pre_tick;
    wire cnt_done;

    // Select code to terminal prescaler count, ratio minus one.
    // Every three-bit code is in the table; the last ratio is the default.
    always @* begin
        case (wc_sel_q)
            `WDPR_PS_DIV2: begin
                pre_last = 8'h01;
            end
            `WDPR_PS_DIV4: begin
                pre_last = 8'h03;
            end
            `WDPR_PS_DIV8: begin
                pre_last = 8'h07;
            end
            `WDPR_PS_DIV16: begin
                pre_last = 8'h0F;
            end
            `WDPR_PS_DIV32: begin
                pre_last = 8'h1F;
            end
            `WDPR_PS_DIV64: begin
                pre_last = 8'h3F;
            end
            `WDPR_PS_DIV128: begin
                pre_last = 8'h7F;
            end
            default: begin
                pre_last = 8'hFF;
            end
        endcase
    end

    // Counting needs the enable, no power-down, and idle only with idle-run.
    assign wdt_run = wc_run_en_q & ~pc_pd_q & (~pc_idle_q | wc_idle_run_q);
    assign pre_tick = wdt_run & mc_tick & (pre_q >= pre_last);
    assign cnt_done = pre_tick & (cnt_q == `WDPR_CNT_LAST);

    // The prescaler steps once per machine cycle while counting is allowed.
    always @(posedge mclk_in) begin
        if (any_reset) begin
            pre_q <= 8'h00;
        end else if (wc_clear_q & mc_tick) begin
            pre_q <= 8'h00;
        end else if (pre_tick) begin
            pre_q <= 8'h00;
        end else if (wdt_run & mc_tick) begin
            pre_q <= pre_q + 8'h01;
        end
    end

    // Period is 12 x ratio x 2^14 oscillator periods; the counter wraps to
    // zero at the time-out edge and is then held clear by the reset.
    always @(posedge mclk_in) begin
        if (any_reset) begin
            cnt_q <= {`WDPR_CNT_W{1'b0}};
        end else if (wc_clear_q & mc_tick) begin
            cnt_q <= {`WDPR_CNT_W{1'b0}};
        end else if (pre_tick) begin
            cnt_q <= cnt_q + 14'h0001;
        end
    end

    // A time-out raises a one-cycle fire pulse that starts the internal reset.
    always @(posedge mclk_in) begin
        if (rst_in | pin_reset) begin
            wdt_fire_q <= 1'b0;
        end else if (wdt_fire_q) begin
            wdt_fire_q <= 1'b0;
        end else if (cnt_done & wc_run_en_q & ~wc_clear_q) begin
            wdt_fire_q <= 1'b1;
        end
    end

    // The internal reset then lasts until two more machine cycles have ended.
    always @(posedge mclk_in) begin
        if (rst_in | pin_reset) begin
            wdt_hold_q <= 2'h0;
        end else if (wdt_fire_q) begin
            wdt_hold_q <= `WDPR_WDT_RST_MC;
        end else if (mc_tick && wdt_hold_q != 2'h0) begin
            wdt_hold_q <= wdt_hold_q - 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs: clock enables, mode flags and the system reset.

    // The system reset and the time-out pulse.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            sys_reset_out <= 1'b1;
            wdt_timeout_out <= 1'b0;
        end else begin
            sys_reset_out <= any_reset;
            wdt_timeout_out <= wdt_fire_q;
        end
    end

    // Clock enables: the processor stops in idle, everything in power-down.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            cpu_clk_en_out <= 1'b0;
            periph_clk_en_out <= 1'b0;
            osc_run_out <= 1'b1;
        end else begin
            cpu_clk_en_out <= phase_q & ~pc_idle_q & ~pc_pd_q;
            periph_clk_en_out <= phase_q & ~pc_pd_q;
            osc_run_out <= ~pc_pd_q;
        end
    end

    // Mode flags seen by the core.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            idle_out <= 1'b0;
            powerdown_out <= 1'b0;
        end else begin
            idle_out <= pc_idle_q;
            powerdown_out <= pc_pd_q;
        end
    end

endmodule // wdpr_top

`default_nettype wire
